// ### hdl/tam_pkg.sv
// Purpose: Constants and types for the trigger arming and measurement rate block
// Assumes: CLK at 100 MHz, register port with read data one cycle after the read strobe
// Notes:   Numeric setpoint fields are raw words; text formatting is done by firmware
//
// Contract
// - With continuous mode off, an initiate command arms the trigger for exactly one trigger.
// - A bus trigger completes an armed sequence only while the bus source is selected.
// - An accepted trigger loads the stored trigger voltage and current into the output setpoints.
// - After one trigger in single mode, further triggers are ignored until initiate or continuous on.
// - Continuous mode keeps the trigger armed, except for one cycle after an external trigger, and makes initiate a no-op.
// - Continuous mode with bus source holds the waiting-for-trigger flag (status bit 5) at 1.
// - Continuous mode with external source drops the flag to 0 on a trigger, then sets it back to 1.
// - With enable bit 5 set, transitions of the waiting flag set event bit 5.
// - The reset command turns continuous mode off and clears the waiting flag.
// - Continuous mode is written as 1 (on) or 0 (off).
// - Reading the continuous setting returns 1 when on and 0 when off.
// - The rate select accepts only 50, 60 or 125 Hz; other values are refused.
// - The sample windows are 20 ms, 16.6 ms and 10 ms for 50, 60 and 125 Hz.
// - The measured current is returned as a mantissa and a decimal exponent.
// - Trigger setpoint reads return the stored trigger values, not the present setpoints.
// - Abort disarms a single armed trigger and clears the flag; no effect in continuous mode.
package tam_pkg;

  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned WIN50_US       = 20_000;
  localparam int unsigned WIN60_US       = 16_600;
  localparam int unsigned WIN125_US      = 10_000;
  localparam int unsigned WIN50_CYC      = WIN50_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WIN60_CYC      = WIN60_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WIN125_CYC     = WIN125_US * (CLK_HZ / 1_000_000);

  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_CMD        = 8'h04;
  localparam logic [7:0] ADDR_RATE       = 8'h08;
  localparam logic [7:0] ADDR_TRIG_VOLT  = 8'h0c;
  localparam logic [7:0] ADDR_TRIG_CURR  = 8'h10;
  localparam logic [7:0] ADDR_OUT_VOLT   = 8'h14;
  localparam logic [7:0] ADDR_OUT_CURR   = 8'h18;
  localparam logic [7:0] ADDR_OPER_COND  = 8'h1c;
  localparam logic [7:0] ADDR_OPER_ENAB  = 8'h20;
  localparam logic [7:0] ADDR_OPER_EVENT = 8'h24;
  localparam logic [7:0] ADDR_MEAS_CURR  = 8'h28;
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h2c;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h30;

  localparam int unsigned CTRL_CONT_BIT  = 0;
  localparam int unsigned CTRL_SRC_BIT   = 1;
  localparam int unsigned CMD_INIT_BIT   = 0;
  localparam int unsigned CMD_ABORT_BIT  = 1;
  localparam int unsigned CMD_BUSTRG_BIT = 2;
  localparam int unsigned CMD_RST_BIT    = 3;
  localparam int unsigned WAITING_FOR_TRIGGER_FLAG_BIT = 5;
  localparam int unsigned IRQ_TRIG_BIT   = 0;
  localparam int unsigned IRQ_SAMP_BIT   = 1;
  localparam int unsigned IRQ_BADRATE_BIT = 2;

  localparam logic [7:0] RATE_50         = 8'h32;
  localparam logic [7:0] RATE_60         = 8'h3c;
  localparam logic [7:0] RATE_125        = 8'h7d;
  localparam logic [7:0] RATE_RST        = RATE_60;

  typedef enum logic { TAM_SRC_BUS, TAM_SRC_EXT } tam_src_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } tam_bus_req_t;

  typedef struct packed {
    logic [23:0] mant;
    logic [7:0]  exp10;
  } tam_sci_t;

endpackage : tam_pkg

// ### hdl/tam_trigger_arm.sv
// Purpose: Trigger arming, waiting flag, operation status and measurement window timing
// Assumes: External trigger arrives asynchronously on EXT_TRIG; meter core supplies current in scientific form
// Notes:   Command register bits are write-one pulses; several in one write act in a fixed order
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module tam_trigger_arm
  import tam_pkg::*;
#(
  parameter int unsigned WIN50_CYCLES  = tam_pkg::WIN50_CYC,
  parameter int unsigned WIN60_CYCLES  = tam_pkg::WIN60_CYC,
  parameter int unsigned WIN125_CYCLES = tam_pkg::WIN125_CYC
)
(
  input  wire logic          CLK,
  input  wire logic          SYS_RST,
  input  tam_pkg::tam_bus_req_t BUS_REQ,
  output logic [31:0]        RD_DATA,
  input  wire logic          EXT_TRIG,
  input  tam_pkg::tam_sci_t  MEAS_CURR,
  output logic [31:0]        OUT_VOLT,
  output logic [31:0]        OUT_CURR,
  output logic               SAMPLE_STROBE,
  output logic               IRQ
);
  import tam_pkg::*;

  typedef enum logic [1:0] { ST_IDLE, ST_ARMED, ST_REARM } tam_arm_st_t;

  typedef struct packed {
    tam_arm_st_t arm;
    logic        cont;
    tam_src_t    src;
    logic [7:0]  rate;
    logic [31:0] trig_volt;
    logic [31:0] trig_curr;
    logic [31:0] out_volt;
    logic [31:0] out_curr;
    logic        waiting_for_trigger_flag;
    logic        flag_prev;
    logic [15:0] oper_enab;
    logic [15:0] oper_event;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic        irq;
    logic [31:0] rdata;
    logic [20:0] win_cnt;
    logic        samp;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_s3;
  } tam_state_t;

  tam_state_t s_q;
  tam_state_t s_d;

  // Reload value is one less than the window, since zero also counts
  function automatic logic [20:0] win_len(input logic [7:0] rate);
    case (rate)
      RATE_50:
      begin
        win_len = 21'(WIN50_CYCLES - 1);
      end
      RATE_125:
      begin
        win_len = 21'(WIN125_CYCLES - 1);
      end
      default:
      begin
        // Refused codes never reach the rate field; 60 Hz is the normal rate
        win_len = 21'(WIN60_CYCLES - 1);
      end
    endcase
  endfunction : win_len

  function automatic logic rate_ok(input logic [31:0] v);
    rate_ok = (v == 32'(RATE_50)) || (v == 32'(RATE_60)) || (v == 32'(RATE_125));
  endfunction : rate_ok

  logic wr_cmd;
  logic do_init;
  logic do_abort;
  logic do_bustrg;
  logic do_rst;
  logic ext_edge;
  logic trig_take;
  logic [2:0] irq_set;

  always_comb
  begin
    s_d       = s_q;
    irq_set   = 3'h0;
    wr_cmd    = BUS_REQ.wr && (BUS_REQ.addr == ADDR_CMD);
    do_init   = wr_cmd && BUS_REQ.wdata[CMD_INIT_BIT];
    do_abort  = wr_cmd && BUS_REQ.wdata[CMD_ABORT_BIT];
    do_bustrg = wr_cmd && BUS_REQ.wdata[CMD_BUSTRG_BIT];
    do_rst    = wr_cmd && BUS_REQ.wdata[CMD_RST_BIT];

    // Only the second and third stages feed the edge detector
    s_d.ext_s1 = EXT_TRIG;
    s_d.ext_s2 = s_q.ext_s1;
    s_d.ext_s3 = s_q.ext_s2;
    ext_edge   = s_q.ext_s2 && !s_q.ext_s3;

    // A trigger counts only while armed and only from the selected source
    trig_take = 1'b0;
    if (s_q.arm == ST_ARMED)
    begin
      if (s_q.src == TAM_SRC_BUS)
      begin
        trig_take = do_bustrg;
      end
      else
      begin
        trig_take = ext_edge;
      end
    end

    // Register writes
    if (BUS_REQ.wr)
    begin
      case (BUS_REQ.addr)
        ADDR_CTRL:
        begin
          s_d.cont = BUS_REQ.wdata[CTRL_CONT_BIT];
          s_d.src  = tam_src_t'(BUS_REQ.wdata[CTRL_SRC_BIT]);
        end
        ADDR_RATE:
        begin
          // A refused rate keeps the running window and flags the host
          if (rate_ok(BUS_REQ.wdata))
          begin
            s_d.rate = BUS_REQ.wdata[7:0];
          end
          else
          begin
            irq_set[IRQ_BADRATE_BIT] = 1'b1;
          end
        end
        ADDR_TRIG_VOLT:
        begin
          s_d.trig_volt = BUS_REQ.wdata;
        end
        ADDR_TRIG_CURR:
        begin
          s_d.trig_curr = BUS_REQ.wdata;
        end
        ADDR_OUT_VOLT:
        begin
          s_d.out_volt = BUS_REQ.wdata;
        end
        ADDR_OUT_CURR:
        begin
          s_d.out_curr = BUS_REQ.wdata;
        end
        ADDR_OPER_ENAB:
        begin
          s_d.oper_enab = BUS_REQ.wdata[15:0];
        end
        ADDR_OPER_EVENT:
        begin
          s_d.oper_event = s_q.oper_event & ~BUS_REQ.wdata[15:0];
        end
        ADDR_IRQ_STAT:
        begin
          s_d.irq_stat = s_q.irq_stat & ~BUS_REQ.wdata[2:0];
        end
        ADDR_IRQ_MASK:
        begin
          s_d.irq_mask = BUS_REQ.wdata[2:0];
        end
        default:
        begin
          // Command word and read-only addresses hold no plain storage
        end
      endcase
    end

    // Accepted trigger loads the stored setpoints
    if (trig_take)
    begin
      s_d.out_volt = s_q.trig_volt;
      s_d.out_curr = s_q.trig_curr;
      irq_set[IRQ_TRIG_BIT] = 1'b1;
    end

    case (s_q.arm)
      ST_IDLE:
      begin
        if (s_d.cont)
        begin
          s_d.arm = ST_ARMED;
        end
        else if (do_init)
        begin
          s_d.arm = ST_ARMED;
        end
      end
      ST_ARMED:
      begin
        if (trig_take && !s_q.cont)
        begin
          s_d.arm = ST_IDLE;
        end
        else if (trig_take && (s_q.src == TAM_SRC_EXT))
        begin
          s_d.arm = ST_REARM;
        end
        else if (trig_take)
        begin
          // Bus source in continuous mode never drops the flag
          s_d.arm = ST_ARMED;
        end
        else if (do_abort && !s_q.cont)
        begin
          s_d.arm = ST_IDLE;
        end
        else if (!s_d.cont && s_q.cont)
        begin
          s_d.arm = ST_IDLE;
        end
      end
      ST_REARM:
      begin
        // One cycle low on the flag so the dip is visible
        s_d.arm = s_d.cont ? ST_ARMED : ST_IDLE;
      end
      default:
      begin
        s_d.arm = ST_IDLE;
      end
    endcase

    // Reset command beats every other arming change
    if (do_rst)
    begin
      s_d.cont = 1'b0;
      s_d.arm  = ST_IDLE;
    end

    s_d.waiting_for_trigger_flag = (s_d.arm == ST_ARMED);
    s_d.flag_prev                = s_q.waiting_for_trigger_flag;
    // Set wins over a simultaneous clear write
    if ((s_q.waiting_for_trigger_flag != s_q.flag_prev) && s_q.oper_enab[WAITING_FOR_TRIGGER_FLAG_BIT])
    begin
      s_d.oper_event[WAITING_FOR_TRIGGER_FLAG_BIT] = 1'b1;
    end

    // Rate changes take effect at the next window boundary
    s_d.samp = 1'b0;
    if (s_q.win_cnt == 21'h0)
    begin
      s_d.win_cnt = win_len(s_q.rate);
      s_d.samp    = 1'b1;
      irq_set[IRQ_SAMP_BIT] = 1'b1;
    end
    else
    begin
      s_d.win_cnt = s_q.win_cnt - 21'h1;
    end

    s_d.irq_stat = s_d.irq_stat | irq_set;
    s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);

    // Read data stands only in the cycle after the strobe
    s_d.rdata = 32'h0;
    if (BUS_REQ.rd)
    begin
      case (BUS_REQ.addr)
        ADDR_CTRL:
        begin
          s_d.rdata = {30'h0, s_q.src, s_q.cont};
        end
        ADDR_RATE:
        begin
          s_d.rdata = {24'h0, s_q.rate};
        end
        ADDR_TRIG_VOLT:
        begin
          s_d.rdata = s_q.trig_volt;
        end
        ADDR_TRIG_CURR:
        begin
          s_d.rdata = s_q.trig_curr;
        end
        ADDR_OUT_VOLT:
        begin
          s_d.rdata = s_q.out_volt;
        end
        ADDR_OUT_CURR:
        begin
          s_d.rdata = s_q.out_curr;
        end
        ADDR_OPER_COND:
        begin
          s_d.rdata = 32'(s_q.waiting_for_trigger_flag) << WAITING_FOR_TRIGGER_FLAG_BIT;
        end
        ADDR_OPER_ENAB:
        begin
          s_d.rdata = {16'h0, s_q.oper_enab};
        end
        ADDR_OPER_EVENT:
        begin
          s_d.rdata = {16'h0, s_q.oper_event};
        end
        ADDR_MEAS_CURR:
        begin
          s_d.rdata = MEAS_CURR;
        end
        ADDR_IRQ_STAT:
        begin
          s_d.rdata = {29'h0, s_q.irq_stat};
        end
        ADDR_IRQ_MASK:
        begin
          s_d.rdata = {29'h0, s_q.irq_mask};
        end
        default:
        begin
          s_d.rdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      s_q         <= '0;
      s_q.arm     <= ST_IDLE;
      s_q.src     <= TAM_SRC_BUS;
      s_q.rate    <= RATE_RST;
    end
    else
      s_q <= s_d;
  end

  assign RD_DATA       = s_q.rdata;
  assign OUT_VOLT      = s_q.out_volt;
  assign OUT_CURR      = s_q.out_curr;
  assign SAMPLE_STROBE = s_q.samp;
  assign IRQ           = s_q.irq;

endmodule : tam_trigger_arm

// ### verif/tam_field_model.sv
// Purpose: External trigger source and meter core
// Assumes: fire is a one-cycle request
// Notes:   Pulse held 6 cycles so the sync stages always see it
`timescale 1ns/10ps
module tam_field_model
  import tam_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         fire,
  output logic              ext_trig,
  output tam_pkg::tam_sci_t meas_curr
);
  import tam_pkg::*;
  int unsigned hold_cnt = 0;
  // 4.99E-2 as mantissa 499, exponent -4
  assign meas_curr = '{mant: 24'h0001f3, exp10: 8'hfc};
  always @(posedge clk)
  begin
    hold_cnt <= fire ? 6 : (hold_cnt != 0 ? hold_cnt - 1 : 0);
    ext_trig <= fire || hold_cnt > 1;
  end
endmodule : tam_field_model

// ### verif/tam_trigger_arm_monitor.sv
// Purpose: Port checks for the trigger arming block
// Assumes: Short sim windows, 20 cycles at most
// Notes:   Read data may only show in the cycle after a read
`timescale 1ns/10ps
module tam_trigger_arm_monitor
  import tam_pkg::*;
#(
  parameter int unsigned WIN50_CYCLES  = 20,
  parameter int unsigned WIN60_CYCLES  = 16,
  parameter int unsigned WIN125_CYCLES = 10
)
(
  input wire logic            CLK,
  input wire logic            SYS_RST,
  input tam_pkg::tam_bus_req_t BUS_REQ,
  input wire logic [31:0]     RD_DATA,
  input wire logic            EXT_TRIG,
  input tam_pkg::tam_sci_t    MEAS_CURR,
  input wire logic [31:0]     OUT_VOLT,
  input wire logic [31:0]     OUT_CURR,
  input wire logic            SAMPLE_STROBE,
  input wire logic            IRQ
);
  import tam_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_quiet;
    !SAMPLE_STROBE [*3];
  endsequence
  // Setpoints move only after a write or a synced external edge
  sequence s_cause;
    $past(BUS_REQ.wr) || $past(EXT_TRIG, 3) || $past(EXT_TRIG, 4);
  endsequence
  a_read_idle_zero: assert property (!$past(BUS_REQ.rd) |-> RD_DATA == 32'h0)
    else $error("read data outside read cycle");
  a_unmapped_reads_zero: assert property (BUS_REQ.rd && BUS_REQ.addr == 8'hfc |=> RD_DATA == 32'h0)
    else $error("unmapped read not zero");
  a_volt_load_cause: assert property ($changed(OUT_VOLT) |-> s_cause)
    else $error("voltage setpoint moved without cause");
  a_curr_load_cause: assert property ($changed(OUT_CURR) |-> s_cause)
    else $error("current setpoint moved without cause");
  a_strobe_gap: assert property (SAMPLE_STROBE |=> s_quiet)
    else $error("sample strobes too close");
  a_strobe_period: assert property (SAMPLE_STROBE |-> ##[1:20] SAMPLE_STROBE)
    else $error("sample window too long");
  a_strobe_start: assert property ($fell(SYS_RST) |-> ##[0:1] SAMPLE_STROBE)
    else $error("no strobe after reset");
  a_reset_outputs: assert property ($fell(SYS_RST) |-> OUT_VOLT == 32'h0 && OUT_CURR == 32'h0 && !IRQ)
    else $error("outputs not cleared by reset");
endmodule : tam_trigger_arm_monitor

bind tam_trigger_arm tam_trigger_arm_monitor #(.WIN50_CYCLES(WIN50_CYCLES), .WIN60_CYCLES(WIN60_CYCLES),
  .WIN125_CYCLES(WIN125_CYCLES)) u_mon (.CLK(CLK), .SYS_RST(SYS_RST), .BUS_REQ(BUS_REQ), .RD_DATA(RD_DATA),
  .EXT_TRIG(EXT_TRIG), .MEAS_CURR(MEAS_CURR), .OUT_VOLT(OUT_VOLT), .OUT_CURR(OUT_CURR),
  .SAMPLE_STROBE(SAMPLE_STROBE), .IRQ(IRQ));

// ### verif/tam_trigger_arm_tb.sv
// Purpose: Self-checking bench for the trigger arming block
// Assumes: Windows shortened to 20, 16 and 10 cycles
// Notes:   All register traffic goes through wr and rd
`timescale 1ns/10ps
module tam_trigger_arm_tb;
  import tam_pkg::*;
  logic         clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         fire = 1'b0;
  tam_bus_req_t bus_req = '0;
  logic [31:0]  rd_data, out_volt, out_curr;
  logic         ext_trig, sample_strobe, irq;
  tam_sci_t     meas_curr;
  int unsigned  bad_count = 0;
  int unsigned  samples_checked = 0;
  int unsigned  n;
  logic [7:0]   rates [3] = '{RATE_50, RATE_60, RATE_125};
  int unsigned  wins [3] = '{20, 16, 10};

  always #5 clk = ~clk;

  tam_trigger_arm #(.WIN50_CYCLES(20), .WIN60_CYCLES(16), .WIN125_CYCLES(10)) uut (.CLK(clk), .SYS_RST(sys_rst),
    .BUS_REQ(bus_req), .RD_DATA(rd_data), .EXT_TRIG(ext_trig), .MEAS_CURR(meas_curr), .OUT_VOLT(out_volt),
    .OUT_CURR(out_curr), .SAMPLE_STROBE(sample_strobe), .IRQ(irq));
  tam_field_model u_field (.clk(clk), .fire(fire), .ext_trig(ext_trig), .meas_curr(meas_curr));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), rd_data & m, exp);
  endtask : rd

  task automatic next_strobe();
    n = 0;
    do
    begin
      @(posedge clk) #1;
      n++;
    end
    while (sample_strobe !== 1'b1 && n < 60);
  endtask : next_strobe

  task automatic irq_is(input logic exp);
    repeat (3) @(posedge clk);
    #1 chk("irq", {31'h0, irq}, {31'h0, exp});
  endtask : irq_is

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    test_done();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_RATE, {24'h0, RATE_RST});
    rd(8'hfc, 32'h0);
    rd(ADDR_MEAS_CURR, 32'h0001f3fc);
    wr(ADDR_TRIG_VOLT, 32'hf);
    wr(ADDR_TRIG_CURR, 32'h3);
    wr(ADDR_OUT_VOLT, 32'h5);
    rd(ADDR_TRIG_CURR, 32'h3);
    rd(ADDR_TRIG_VOLT, 32'hf);
    rd(ADDR_OUT_VOLT, 32'h5);
    wr(ADDR_CMD, 32'h4);
    rd(ADDR_OUT_VOLT, 32'h5);
    chk("out_volt pin", out_volt, 32'h5);
    wr(ADDR_CMD, 32'h1);
    rd(ADDR_OPER_COND, 32'h20);
    wr(ADDR_CMD, 32'h4);
    rd(ADDR_OUT_VOLT, 32'hf);
    rd(ADDR_OUT_CURR, 32'h3);
    chk("out_volt pin", out_volt, 32'hf);
    chk("out_curr pin", out_curr, 32'h3);
    rd(ADDR_OPER_COND, 32'h0);
    wr(ADDR_TRIG_VOLT, 32'h7);
    wr(ADDR_CMD, 32'h4);
    rd(ADDR_OUT_VOLT, 32'hf);
    wr(ADDR_CMD, 32'h1);
    wr(ADDR_CMD, 32'h2);
    rd(ADDR_OPER_COND, 32'h0);
    wr(ADDR_CMD, 32'h4);
    rd(ADDR_OUT_VOLT, 32'hf);
    wr(ADDR_OPER_ENAB, 32'h20);
    wr(ADDR_CTRL, 32'h1);
    rd(ADDR_CTRL, 32'h1);
    rd(ADDR_OPER_EVENT, 32'h20);
    wr(ADDR_OPER_EVENT, 32'h20);
    // Init and abort beside a bus trigger: both must be no-ops here
    wr(ADDR_CMD, 32'h7);
    rd(ADDR_OUT_VOLT, 32'h7);
    rd(ADDR_OPER_COND, 32'h20);
    rd(ADDR_OPER_EVENT, 32'h0);
    wr(ADDR_CTRL, 32'h3);
    wr(ADDR_TRIG_VOLT, 32'h9);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (12) @(posedge clk);
    rd(ADDR_OUT_VOLT, 32'h9);
    rd(ADDR_OPER_COND, 32'h20);
    chk("out_volt pin", out_volt, 32'h9);
    rd(ADDR_OPER_EVENT, 32'h20);
    rd(ADDR_IRQ_STAT, 32'h3, 32'h3);
    wr(ADDR_CMD, 32'h8);
    rd(ADDR_CTRL, 32'h0, 32'h1);
    rd(ADDR_OPER_COND, 32'h0);
    foreach (rates[i])
    begin
      wr(ADDR_RATE, {24'h0, rates[i]});
      rd(ADDR_RATE, {24'h0, rates[i]});
      next_strobe();
      next_strobe();
      chk("window", n, wins[i]);
    end
    wr(ADDR_IRQ_STAT, 32'h7);
    wr(ADDR_IRQ_MASK, 32'h4);
    wr(ADDR_RATE, 32'h40);
    rd(ADDR_RATE, {24'h0, RATE_125});
    rd(ADDR_IRQ_STAT, 32'h4, 32'h4);
    irq_is(1'b1);
    wr(ADDR_IRQ_MASK, 32'h0);
    irq_is(1'b0);
    wr(ADDR_IRQ_MASK, 32'h4);
    irq_is(1'b1);
    wr(ADDR_IRQ_STAT, 32'h4);
    irq_is(1'b0);
    test_done();
  end
endmodule : tam_trigger_arm_tb
